/* rtl/lca_top.sv */
// Twelve channel change flag and live alarm registers behind the parallel register port
`timescale 1ns/100ps
`default_nettype none
`include "lca_regs.svh"

module lca_top (
    input  wire logic        CLK_SYS,               // System clock, 200 MHz
    input  wire logic        NRST,                  // Asynchronous reset, active low
    input  wire logic        CS_N,                  // Chip select, active low
    input  wire logic        RD_N,                  // Read strobe, active low
    input  wire logic [7:0]  ADDR,                  // Register address
    output logic      [7:0]  DATA_O,                // Read data
    output logic             DATA_OE,               // Data bus drive enable
    input  wire logic [11:0] RX_BIT_STB,            // Bit period strobe per channel
    input  wire logic [11:0] RX_BIT,                // Pulse present in bit period
    input  wire logic [11:0] ANALOG_LOS,            // Analog detector per channel
    input  wire logic [11:0] CLOCK_RECOVERY_UNLOCK, // Recovery unlock per channel
    input  wire logic [11:0] DRIVE_MONITOR_OUTPUT,  // Transmit drive monitor per channel
    input  wire logic [11:0] PRBS_RX_EN,            // Pattern receiver enable
    input  wire logic [11:0] LOS_CHG_EN,            // Loss of signal change enable
    input  wire logic [11:0] DRIVE_CHG_EN           // Drive monitor change enable
);

    // ============================================================
    // Declarations
    lca_pkg::lca_state_t st_reg;    // Registered state
    lca_pkg::lca_state_t st_next;   // Next state
    logic [11:0]         dlos_w;    // Digital detector outputs
    logic [11:0]         prbs_w;    // Pattern receiver outputs
    logic                rd_start;  // First cycle of a read access
    logic                ch_valid;  // High nibble names a channel
    logic [3:0]          ch;        // Decoded channel index
    logic                is_chg;    // Access to change flag register
    logic                is_alm;    // Access to alarm register
    logic [7:0]          rd_val;    // Byte presented on a read
    logic [11:0]         clr_mask;  // Channel whose flags a read clears
    logic [11:0]         los_evt;   // Enabled loss of signal changes
    logic [11:0]         drive_evt; // Enabled drive monitor changes
    logic [4:0]          ch_dec;    // Valid bit and channel index

    // ============================================================
    // Channel decode: nibbles 0-5 map to 0-5, nibbles 8-D to 6-11
    // Unnamed nibbles answer a zero byte instead of aliasing onto
    // a live channel, so a stray read never clears another
    // channel's flags
    function automatic logic [4:0] chan_of(input logic [3:0] hi);
        logic [4:0] r;
        r = 5'h00;
        if (hi <= 4'h5) begin
            r = {1'b1, hi};
        end else if (hi >= 4'h8 && hi <= 4'hD) begin
            r = {1'b1, hi - 4'h2};
        end
        return r;
    endfunction : chan_of

    // ============================================================
    // Per channel detectors
    // Both see the same strobe and bit; the pattern receiver
    // only counts while its enable is high
    for (genvar i = 0; i < 12; i++) begin : g_chan
        lca_dlos u_dlos (
            .clk_sys   (CLK_SYS),
            .nrst      (NRST),
            .bit_stb   (RX_BIT_STB[i]),
            .bit_pulse (RX_BIT[i]),
            .los       (dlos_w[i])
        );
        lca_prbs_rx u_prbs (
            .clk_sys (CLK_SYS),
            .nrst    (NRST),
            .enable  (PRBS_RX_EN[i]),
            .bit_stb (RX_BIT_STB[i]),
            .bit_in  (RX_BIT[i]),
            .lost    (prbs_w[i])
        );
    end

    // ============================================================
    // Next state: live alarms, sticky flags and the read sequencer
    // Live copies cost a cycle of latency but keep the read byte
    // steady when a pin moves during the access
    always_comb begin
        st_next  = st_reg;
        rd_start = !CS_N && !RD_N && (st_reg.bus_fsm == lca_pkg::LCA_BUS_IDLE);
        ch_dec   = chan_of(ADDR[7:4]);
        ch_valid = ch_dec[4];
        ch       = ch_dec[3:0];
        is_chg   = ch_valid && (ADDR[3:0] == `LCA_OFS_CHANGE);
        is_alm   = ch_valid && (ADDR[3:0] == `LCA_OFS_ALARM);
        rd_val   = `LCA_RST_BYTE;
        clr_mask = `LCA_RST_CHAN;

        st_next.los_all  = ANALOG_LOS | dlos_w;
        st_next.alos_r   = ANALOG_LOS;
        st_next.dlos_r   = dlos_w;
        st_next.prbs_r   = prbs_w;
        st_next.unlock_r = CLOCK_RECOVERY_UNLOCK;
        st_next.drive_r  = DRIVE_MONITOR_OUTPUT;
        st_next.los_prev   = st_reg.los_all;
        st_next.drive_prev = st_reg.drive_r;

        // change needs its enable
        // The enable gates only the setting; a flag already set
        // stays until the host reads it
        los_evt   = (st_reg.los_all ^ st_reg.los_prev) & LOS_CHG_EN;
        drive_evt = (st_reg.drive_r ^ st_reg.drive_prev) & DRIVE_CHG_EN;

        // Read data; reserved bits stay at zero
        if (is_chg) begin
            rd_val[`LCA_CHG_LOS_BIT]   = st_reg.los_flag[ch];
            rd_val[`LCA_CHG_DRIVE_BIT] = st_reg.drive_flag[ch];
        end else if (is_alm) begin
            rd_val[`LCA_ALM_LOS_BIT]    = st_reg.los_all[ch];
            rd_val[`LCA_ALM_DRIVE_BIT]  = st_reg.drive_r[ch];
            rd_val[`LCA_ALM_UNLOCK_BIT] = st_reg.unlock_r[ch];
            rd_val[`LCA_ALM_PRBS_BIT]   = st_reg.prbs_r[ch];
            rd_val[`LCA_ALM_ALOS_BIT]   = st_reg.alos_r[ch];
            rd_val[`LCA_ALM_DLOS_BIT]   = st_reg.dlos_r[ch];
        end

        // Register port sequencer; writes are not decoded, so nothing here changes
        // A held strobe is one access: the host lifts RD_N or CS_N
        // before the next read, so a slow host cannot clear twice
        case (st_reg.bus_fsm)
            lca_pkg::LCA_BUS_IDLE: begin
                if (rd_start) begin
                    st_next.data_o  = rd_val;
                    st_next.data_oe = 1'b1;
                    st_next.bus_fsm = lca_pkg::LCA_BUS_READ;
                    if (is_chg) begin
                        clr_mask[ch] = 1'b1;
                    end
                end
            end
            lca_pkg::LCA_BUS_READ: begin
                // Data holds steady until the strobe or select goes away
                if (CS_N || RD_N) begin
                    st_next.data_o  = `LCA_RST_BYTE;
                    st_next.data_oe = 1'b0;
                    st_next.bus_fsm = lca_pkg::LCA_BUS_IDLE;
                end
            end
            default: begin
                st_next.data_o  = `LCA_RST_BYTE;
                st_next.data_oe = 1'b0;
                st_next.bus_fsm = lca_pkg::LCA_BUS_IDLE;
            end
        endcase

        // loss of signal and drive monitor flags
        // A change in the clearing cycle wins, so no event is dropped
        st_next.los_flag   = (st_reg.los_flag & ~clr_mask) | los_evt;
        st_next.drive_flag = (st_reg.drive_flag & ~clr_mask) | drive_evt;
    end

    // ============================================================
    // State register
    // All fields but bus_fsm clear on reset; the sequencer returns to idle
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            st_reg <= '{bus_fsm: lca_pkg::LCA_BUS_IDLE, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ============================================================
    // Outputs straight from the state register
    assign DATA_O  = st_reg.data_o;
    assign DATA_OE = st_reg.data_oe;

    // ============================================================
    // Checks
    // Read checks use the registered copies one edge back; the
    // copies except alos_r are checked against their sources apart
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);

    chk_read_drives_bus: assert property (
        rd_start |=> DATA_OE && DATA_O == $past(rd_val))
        else $error("read did not drive the decoded byte");

    chk_chg_los_read: assert property (
        rd_start && is_chg |=> DATA_O[1] == $past(st_reg.los_flag[ch]))
        else $error("loss of signal flag misread");

    chk_chg_drive_read: assert property (
        rd_start && is_chg |=> DATA_O[0] == $past(st_reg.drive_flag[ch]))
        else $error("drive monitor flag misread");

    chk_flag_clear_read: assert property (
        rd_start && is_chg && !los_evt[ch] |=> !st_reg.los_flag[$past(ch)])
        else $error("read did not clear the loss of signal flag");

    chk_unmapped_zero: assert property (
        rd_start && !is_chg && !is_alm |=> DATA_O == 8'h00)
        else $error("unmapped read returned nonzero");

    chk_alarm_live_bits: assert property (
        rd_start && is_alm |=> DATA_O[1] == $past(st_reg.los_all[ch])
            && DATA_O[0] == $past(st_reg.drive_r[ch])
            && DATA_O[2] == $past(st_reg.unlock_r[ch]))
        else $error("alarm live bits misread");

    chk_alarm_prbs_bit: assert property (
        rd_start && is_alm |=> DATA_O[6] == $past(st_reg.prbs_r[ch]))
        else $error("pattern lock bit misread");

    chk_los_is_or: assert property (
        ##1 st_reg.los_all == $past(ANALOG_LOS | dlos_w))
        else $error("overall loss of signal is not the OR of detectors");

    chk_set_needs_enable: assert property (
        ##1 (st_reg.los_flag & ~$past(st_reg.los_flag) & ~$past(LOS_CHG_EN)) == 12'h000)
        else $error("disabled loss of signal flag was set");

    chk_reserved_zero: assert property (
        rd_start && (is_chg || is_alm) |=> DATA_O[7] == 1'b0
            && DATA_O[3] == 1'b0 && ($past(is_chg) -> DATA_O[7:2] == 6'h00))
        else $error("reserved bits read nonzero");

    chk_read_holds: assert property (
        st_reg.bus_fsm == lca_pkg::LCA_BUS_READ && !CS_N && !RD_N
        |=> DATA_OE && $stable(DATA_O))
        else $error("held read did not keep its byte");

    chk_bus_release: assert property (
        st_reg.bus_fsm == lca_pkg::LCA_BUS_READ && (CS_N || RD_N)
        |=> !DATA_OE && DATA_O == 8'h00)
        else $error("released read left the bus driven");

    chk_oe_idle: assert property (
        st_reg.bus_fsm == lca_pkg::LCA_BUS_IDLE && !rd_start |=> !DATA_OE)
        else $error("bus driven without a read");

    chk_drive_clear_read: assert property (
        rd_start && is_chg && !drive_evt[ch] |=> !st_reg.drive_flag[$past(ch)])
        else $error("read did not clear the drive monitor flag");

    chk_los_set_wins: assert property (
        rd_start && is_chg && los_evt[ch] |=> st_reg.los_flag[$past(ch)])
        else $error("change in the clearing cycle was lost");

    chk_drive_needs_enable: assert property (
        ##1 (st_reg.drive_flag & ~$past(st_reg.drive_flag) & ~$past(DRIVE_CHG_EN)) == 12'h000)
        else $error("disabled drive monitor flag was set");

    chk_alarm_detector_bits: assert property (
        rd_start && is_alm |=> DATA_O[4] == $past(st_reg.alos_r[ch])
            && DATA_O[5] == $past(st_reg.dlos_r[ch]))
        else $error("detector alarm bits misread");

    chk_dlos_copy: assert property (
        NRST |=> st_reg.dlos_r == $past(dlos_w))
        else $error("digital detector copy wrong");

    chk_prbs_copy: assert property (
        NRST |=> st_reg.prbs_r == $past(prbs_w))
        else $error("pattern lock copy wrong");

    chk_drive_copy: assert property (
        NRST |=> st_reg.drive_r == $past(DRIVE_MONITOR_OUTPUT))
        else $error("drive monitor copy wrong");

    chk_unlock_copy: assert property (
        NRST |=> st_reg.unlock_r == $past(CLOCK_RECOVERY_UNLOCK))
        else $error("recovery unlock copy wrong");

    cov_flag_read_set: cover property (rd_start && is_chg && st_reg.los_flag[ch]);
    cov_alarm_read: cover property (rd_start && is_alm && st_reg.los_all[ch]);
    cov_set_and_clear: cover property (rd_start && is_chg && los_evt[ch]);

endmodule : lca_top

`default_nettype wire

/* rtl/lca_regs.svh */
// Register offsets, field positions and detector counts of the channel alarm status block
`ifndef LCA_REGS_SVH
`define LCA_REGS_SVH

// ============================================================
// Register offsets (low nibble; high nibble selects channel)
`define LCA_OFS_CHANGE        4'h2
`define LCA_OFS_ALARM         4'h3

// ============================================================
// Change flag register fields
`define LCA_CHG_LOS_BIT       1
`define LCA_CHG_DRIVE_BIT     0

// ============================================================
// Alarm register fields
`define LCA_ALM_PRBS_BIT      6
`define LCA_ALM_DLOS_BIT      5
`define LCA_ALM_ALOS_BIT      4
`define LCA_ALM_UNLOCK_BIT    2
`define LCA_ALM_LOS_BIT       1
`define LCA_ALM_DRIVE_BIT     0

// ============================================================
// Reset values
`define LCA_RST_BYTE          8'h00
`define LCA_RST_CHAN          12'h000

// ============================================================
// Digital loss of signal detector counts, in bit periods
`define LCA_DLOS_ZERO_RUN     8'hA0
`define LCA_DLOS_WIN_LAST     8'h1D
`define LCA_DLOS_ONES_MIN     8'h0A

// ============================================================
// Pattern receiver counts, in bit periods
`define LCA_PRBS_WIN_LAST     8'h7F
`define LCA_PRBS_LOSS_ERRS    8'h20
`define LCA_PRBS_CLEAR_ERRS   8'h01

`endif

/* rtl/lca_pkg.sv */
// Types shared by the channel alarm status block and its detectors
package lca_pkg;

    // ============================================================
    // Register port sequencer, one-hot
    typedef enum logic [1:0] {
        LCA_BUS_IDLE = 2'b01,
        LCA_BUS_READ = 2'b10
    } lca_bus_fsm_t;

    // ============================================================
    // Pattern receiver lock state, one-hot
    typedef enum logic [1:0] {
        LCA_PRBS_LOCKED = 2'b01,
        LCA_PRBS_LOST   = 2'b10
    } lca_prbs_fsm_t;

    // ============================================================
    // Top level state
    typedef struct packed {
        lca_bus_fsm_t bus_fsm;    // Read sequencer
        logic [7:0]   data_o;     // Read data driven on the bus
        logic         data_oe;    // Bus drive enable
        logic [11:0]  los_all;    // Overall loss of signal
        logic [11:0]  los_prev;   // Overall loss of signal, one cycle back
        logic [11:0]  drive_r;    // Drive monitor state
        logic [11:0]  drive_prev; // Drive monitor state, one cycle back
        logic [11:0]  unlock_r;   // Clock recovery unlock state
        logic [11:0]  alos_r;     // Analog detector state
        logic [11:0]  dlos_r;     // Digital detector state
        logic [11:0]  prbs_r;     // Pattern lock lost
        logic [11:0]  los_flag;   // Sticky loss of signal change
        logic [11:0]  drive_flag; // Sticky drive monitor change
    } lca_state_t;

    // ============================================================
    // Digital loss of signal detector state
    typedef struct packed {
        logic [7:0] zero_cnt;     // Consecutive empty bit periods
        logic [7:0] win_cnt;      // Position inside density window
        logic [7:0] ones_cnt;     // Pulses inside density window
        logic       los;          // Defect declared
    } lca_dlos_state_t;

    // ============================================================
    // Pattern receiver state
    typedef struct packed {
        lca_prbs_fsm_t fsm;       // Lock state
        logic [14:0]   shreg;     // Last received bits
        logic [7:0]    win_cnt;   // Position inside error window
        logic [7:0]    err_cnt;   // Errors inside error window
    } lca_prbs_state_t;

endpackage : lca_pkg

/* rtl/lca_dlos.sv */
// Digital loss of signal detector for one channel
`timescale 1ns/100ps
`default_nettype none
`include "lca_regs.svh"

module lca_dlos (
    input  wire logic clk_sys,   // System clock
    input  wire logic nrst,      // Asynchronous reset, active low
    input  wire logic bit_stb,   // One pulse per line bit period
    input  wire logic bit_pulse, // Pulse present in this bit period
    output logic      los        // Defect declared
);

    lca_pkg::lca_dlos_state_t st_reg;  // Registered state
    lca_pkg::lca_dlos_state_t st_next; // Next state

    // ============================================================
    // Next state
    always_comb begin
        st_next = st_reg;
        if (bit_stb) begin
            if (bit_pulse) begin
                st_next.zero_cnt = 8'h00;
            end else if (st_reg.zero_cnt != `LCA_DLOS_ZERO_RUN) begin
                st_next.zero_cnt = st_reg.zero_cnt + 8'h01;
            end
            if (!bit_pulse && st_reg.zero_cnt == `LCA_DLOS_ZERO_RUN - 8'h01) begin
                st_next.los = 1'b1;
            end
            if (st_reg.win_cnt == `LCA_DLOS_WIN_LAST) begin
                st_next.win_cnt  = 8'h00;
                st_next.ones_cnt = 8'h00;
                // One third of the window carrying pulses ends the defect
                if (st_reg.ones_cnt + {7'h00, bit_pulse} >= `LCA_DLOS_ONES_MIN) begin
                    st_next.los = 1'b0;
                end
            end else begin
                st_next.win_cnt  = st_reg.win_cnt + 8'h01;
                st_next.ones_cnt = st_reg.ones_cnt + {7'h00, bit_pulse};
            end
        end
    end

    // ============================================================
    // State register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign los = st_reg.los;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    chk_dlos_empty_run: assert property (
        bit_stb && !bit_pulse && st_reg.zero_cnt == 8'h9F |=> los)
        else $error("empty run of 160 did not declare loss of signal");

    cov_dlos_declared: cover property ($rose(los));

endmodule : lca_dlos

`default_nettype wire

/* rtl/lca_prbs_rx.sv */
// Pattern receiver lock monitor for one channel
`timescale 1ns/100ps
`default_nettype none
`include "lca_regs.svh"

module lca_prbs_rx (
    input  wire logic clk_sys, // System clock
    input  wire logic nrst,    // Asynchronous reset, active low
    input  wire logic enable,  // Receiver enabled
    input  wire logic bit_stb, // One pulse per line bit period
    input  wire logic bit_in,  // Received data bit
    output logic      lost     // Loss of pattern lock declared
);

    lca_pkg::lca_prbs_state_t st_reg;  // Registered state
    lca_pkg::lca_prbs_state_t st_next; // Next state
    logic                     err;     // Received bit differs from prediction

    // ============================================================
    // Self-synchronising check: prediction from the last received bits,
    // so lock is found again without a seed exchange
    always_comb begin
        st_next = st_reg;
        err     = bit_in ^ st_reg.shreg[14] ^ st_reg.shreg[13];
        if (!enable) begin
            // Disabled receiver reports loss of lock
            st_next.fsm     = lca_pkg::LCA_PRBS_LOST;
            st_next.win_cnt = 8'h00;
            st_next.err_cnt = 8'h00;
        end else if (bit_stb) begin
            st_next.shreg   = {st_reg.shreg[13:0], bit_in};
            st_next.win_cnt = st_reg.win_cnt + 8'h01;
            st_next.err_cnt = st_reg.err_cnt + {7'h00, err};
            if (st_reg.win_cnt == `LCA_PRBS_WIN_LAST) begin
                st_next.win_cnt = 8'h00;
                st_next.err_cnt = 8'h00;
                case (st_reg.fsm)
                    lca_pkg::LCA_PRBS_LOCKED: begin
                        if (st_reg.err_cnt >= `LCA_PRBS_LOSS_ERRS) begin
                            st_next.fsm = lca_pkg::LCA_PRBS_LOST;
                        end
                    end
                    lca_pkg::LCA_PRBS_LOST: begin
                        if (st_reg.err_cnt <= `LCA_PRBS_CLEAR_ERRS) begin
                            st_next.fsm = lca_pkg::LCA_PRBS_LOCKED;
                        end
                    end
                    default: begin
                        st_next.fsm = lca_pkg::LCA_PRBS_LOST;
                    end
                endcase
            end
        end
    end

    // ============================================================
    // State register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '{fsm: lca_pkg::LCA_PRBS_LOST, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign lost = (st_reg.fsm == lca_pkg::LCA_PRBS_LOST);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    chk_prbs_loss_declare: assert property (
        enable && bit_stb && st_reg.win_cnt == 8'h7F && !lost && st_reg.err_cnt >= 8'h20
        |=> lost)
        else $error("error burst did not declare loss of pattern lock");

    chk_prbs_lock_regain: assert property (
        enable && bit_stb && st_reg.win_cnt == 8'h7F && lost && st_reg.err_cnt <= 8'h01
        |=> !lost)
        else $error("clean window did not clear loss of pattern lock");

    cov_prbs_locked: cover property ($fell(lost));

endmodule : lca_prbs_rx

`default_nettype wire

/* tb/lca_host_model.sv */
// Host model reading the parallel register port
`timescale 1ns/100ps
`default_nettype none

module lca_host_model (
    input  wire logic       clk,     // System clock
    input  wire logic [7:0] data_o,  // Read data
    input  wire logic       data_oe, // Block drives data
    output var logic        cs_n,    // Chip select, active low
    output var logic        rd_n,    // Read strobe, active low
    output var logic [7:0]  addr     // Register address
);
    // ============================================================
    // Idle, deselected bus at time zero
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        addr = 8'h00;
    end

    // ============================================================
    // One read, held until the answer edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        int n;
        n = 0;
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        addr <= a;
        @(posedge clk);
        // Bounded wait so a dead port cannot hang
        while (data_oe !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        d = data_o;
        ok = data_oe;
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        // Released address shows no stale value
        addr <= ~a;
    endtask : rd
endmodule : lca_host_model
`default_nettype wire

/* tb/lca_top_bench.sv */
// Bench for the channel change flag and alarm registers
`timescale 1ns/100ps
`default_nettype none

module lca_top_bench;
    // ============================================================
    // Signals
    logic        CLK_SYS, NRST, CS_N, RD_N, DATA_OE;
    logic [7:0]  ADDR, DATA_O;
    logic [11:0] RX_BIT_STB, RX_BIT, ANALOG_LOS, CLOCK_RECOVERY_UNLOCK;
    logic [11:0] DRIVE_MONITOR_OUTPUT, PRBS_RX_EN, LOS_CHG_EN, DRIVE_CHG_EN;
    logic [14:0] lfsr = 15'h0001; // Looped back pattern source
    int          n_errors = 0;
    int          cmp_count = 0;

    lca_top u_lca_top (.CLK_SYS(CLK_SYS), .NRST(NRST), .CS_N(CS_N), .RD_N(RD_N),
        .ADDR(ADDR), .DATA_O(DATA_O), .DATA_OE(DATA_OE), .RX_BIT_STB(RX_BIT_STB),
        .RX_BIT(RX_BIT), .ANALOG_LOS(ANALOG_LOS),
        .CLOCK_RECOVERY_UNLOCK(CLOCK_RECOVERY_UNLOCK),
        .DRIVE_MONITOR_OUTPUT(DRIVE_MONITOR_OUTPUT), .PRBS_RX_EN(PRBS_RX_EN),
        .LOS_CHG_EN(LOS_CHG_EN), .DRIVE_CHG_EN(DRIVE_CHG_EN));

    lca_host_model u_lca_host_model (.clk(CLK_SYS), .data_o(DATA_O),
        .data_oe(DATA_OE), .cs_n(CS_N), .rd_n(RD_N), .addr(ADDR));

    // ============================================================
    // 200 MHz clock
    initial begin
        CLK_SYS = 1'b0;
        forever #2.5 CLK_SYS = ~CLK_SYS;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask : cyc

    // Read one register and compare the byte
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       ok;
        u_lca_host_model.rd(a, d, ok);
        cmp_count++;
        if (ok !== 1'b1 || d !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, d, e);
        end
    endtask : rc

    // Bit periods on one channel: mode 0 or 1 constant, 2 pattern
    task automatic stb(input int ch, input int mode, input int n);
        logic b;
        repeat (n) begin
            b = (mode == 2) ? (lfsr[14] ^ lfsr[13]) : mode[0];
            // Constant runs must not flush the pattern source to zero
            if (mode == 2) begin
                lfsr = {lfsr[13:0], b};
            end
            @(posedge CLK_SYS);
            RX_BIT_STB[ch] <= 1'b1;
            RX_BIT[ch] <= b;
            @(posedge CLK_SYS);
            RX_BIT_STB[ch] <= 1'b0;
        end
    endtask : stb

    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    // Watchdog, several times the expected run
    initial begin
        #50000;
        n_errors++;
        summarize();
    end

    // ============================================================
    // Main sequence
    initial begin
        {NRST, RX_BIT_STB, RX_BIT, ANALOG_LOS} = '0;
        {CLOCK_RECOVERY_UNLOCK, DRIVE_MONITOR_OUTPUT, PRBS_RX_EN} = '0;
        {LOS_CHG_EN, DRIVE_CHG_EN} = '1;
        cyc(2);
        NRST <= 1'b1;
        cyc(2);
        rc(8'h03, 8'h40);
        rc(8'h02, 8'h00);
        rc(8'h62, 8'h00);
        rc(8'h04, 8'h00);
        // Drive monitor on channel 6, both directions
        DRIVE_MONITOR_OUTPUT[6] <= 1'b1;
        cyc(4);
        rc(8'h83, 8'h41);
        rc(8'h82, 8'h01);
        rc(8'h82, 8'h00);
        DRIVE_MONITOR_OUTPUT[6] <= 1'b0;
        cyc(4);
        rc(8'h82, 8'h01);
        // Disabled change must not set the flag
        DRIVE_CHG_EN[6] <= 1'b0;
        DRIVE_MONITOR_OUTPUT[6] <= 1'b1;
        cyc(4);
        rc(8'h82, 8'h00);
        // Analog loss on channel 11
        ANALOG_LOS[11] <= 1'b1;
        cyc(4);
        rc(8'hD3, 8'h52);
        rc(8'hD2, 8'h02);
        LOS_CHG_EN[11] <= 1'b0;
        ANALOG_LOS[11] <= 1'b0;
        cyc(4);
        rc(8'hD2, 8'h00);
        rc(8'hD3, 8'h40);
        CLOCK_RECOVERY_UNLOCK[0] <= 1'b1;
        cyc(4);
        rc(8'h03, 8'h44);
        // Empty bit run on channel 1, one short then exact
        stb(1, 0, 159);
        cyc(4);
        rc(8'h13, 8'h40);
        stb(1, 0, 1);
        cyc(4);
        rc(8'h13, 8'h62);
        rc(8'h12, 8'h02);
        stb(1, 1, 60);
        cyc(4);
        rc(8'h13, 8'h40);
        rc(8'h12, 8'h02);
        PRBS_RX_EN[2] <= 1'b1;
        stb(2, 2, 400);
        cyc(4);
        rc(8'h23, 8'h00);
        stb(2, 1, 300);
        cyc(4);
        rc(8'h23, 8'h40);
        // Reset in mid-run drops a pending flag
        ANALOG_LOS[3] <= 1'b1;
        cyc(4);
        rc(8'h33, 8'h52);
        NRST <= 1'b0;
        ANALOG_LOS[3] <= 1'b0;
        cyc(2);
        NRST <= 1'b1;
        cyc(2);
        rc(8'h32, 8'h00);
        rc(8'h33, 8'h40);
        summarize();
    end
endmodule : lca_top_bench
`default_nettype wire
